// >>> shared/host_port_two_map.vh
`ifndef HOST_PORT_TWO_MAP_VH
`define HOST_PORT_TWO_MAP_VH

// ==========================================================
// status layout
`define FLAGS_TWO_RESET      8'h00
`define FLAG_CMD_DATA_BIT    3
`define FLAG_INPUT_FULL_BIT  1
`define FLAG_OUTPUT_FULL_BIT 0
`define FLAGS_GP_MASK        8'hF4
`define FLAGS_HW_MASK        8'h0B

// ==========================================================
// serial/timer control layout
`define STC_RESET            8'h00
`define STC_PIN_SWITCH_BIT   3

// ==========================================================
// system control layout
`define SYSCTL_ENABLE_BIT    1

// ==========================================================
// slave register selects
`define SEL_IN_BYTE          2'h0
`define SEL_OUT_BYTE         2'h1
`define SEL_FLAGS            2'h2
`define SEL_STC              2'h3

// ==========================================================
// synchroniser depth
`define SYNC_STAGES          2

`endif

// >>> hw/pin_sync.v
`timescale 1ns/1ps
`include "host_port_two_map.vh"

module pin_sync #(
   parameter WIDTH = 1
) (
   input  wire             clk,
   input  wire             reset,
   input  wire             clk_en,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   // ==========================================================
   // two flops per bit; the first stage feeds only the second
   reg [WIDTH-1:0] stage_one_reg;
   reg [WIDTH-1:0] stage_two_reg;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge clk) begin
            if (reset) begin
               // idle high: strobes and selects are active low
               stage_one_reg[i] <= 1'b1;
               stage_two_reg[i] <= 1'b1;
            end else if (clk_en) begin
               stage_one_reg[i] <= async_in[i];
               stage_two_reg[i] <= stage_one_reg[i];
            end
         end
      end
   endgenerate
   assign sync_out = stage_two_reg;
endmodule

// >>> hw/edge_find.v
`timescale 1ns/1ps

module edge_find (
   input  wire clk,
   input  wire reset,
   input  wire clk_en,
   input  wire level_in,
   output wire rise,
   output wire fall
);
   // ==========================================================
   // edge detector on an already synchronised level
   reg last_reg;
   always @(posedge clk) begin
      if (reset) begin
         last_reg <= 1'b1;
      end else if (clk_en) begin
         last_reg <= level_in;
      end
   end
   assign rise = clk_en & level_in & ~last_reg;
   assign fall = clk_en & ~level_in & last_reg;
endmodule

// >>> hw/host_port_channel_two.v
`timescale 1ns/1ps
`include "host_port_two_map.vh"

// Functional notes
// - output byte driven to host when address low, select low, read low
// - output byte has no reset value; undefined until slave writes
// - status cleared to zero on reset and hardware standby
// - status bits 3, 1, 0 ignore writes from both sides
// - status bits 7..4 and 2 slave read/write, host read only
// - host write rising edge captures address bit into command/data flag
// - command/data flag zero means data, one means command
// - input full set on host write rising edge to input byte
// - input full cleared on falling edge of slave read of input byte
// - input full drives interrupt request toward slave CPU
// - output full set on falling edge of slave write of output byte
// - output full cleared on rising edge of host read of output byte
// - pin switch zero picks first pin pair, one picks alternate pair
// - pin switch only acts while host port enabled in slave mode
// - serial/timer control resets to zero on reset and standby
// - host write with select low latches data bus into input byte
// - host pins and functions active only once enable bit set
module host_port_channel_two (
   input  wire       clk,
   input  wire       reset,
   input  wire       clk_en,
   input  wire       hw_standby,
   input  wire [7:0] system_control_register,
   input  wire       host_address_bit,
   input  wire       host_select_two_n,
   input  wire       host_write_strobe_n,
   input  wire       alt_host_select_two_n,
   input  wire       alt_host_write_strobe_n,
   input  wire       host_read_strobe_n,
   input  wire [7:0] host_data_in,
   output reg  [7:0] host_data_out,
   output reg        host_data_oe_n,
   input  wire [1:0] slave_sel,
   input  wire       slave_rd_strobe,
   input  wire       slave_wr_strobe,
   input  wire [7:0] slave_wdata,
   output reg  [7:0] slave_rdata,
   output reg        input_full_irq,
   output reg        pin_switch_select
);
   // ==========================================================
   // pin synchronisers
   wire [11:0] pins_raw;
   wire [11:0] pins_sync;
   assign pins_raw = {host_data_in, host_address_bit, host_read_strobe_n,
                      host_select_two_n ^ 1'b0, host_write_strobe_n};
   wire [1:0] alt_sync;

   pin_sync #(.WIDTH(12)) u_sync_main (
      .clk      (clk),
      .reset    (reset),
      .clk_en   (clk_en),
      .async_in (pins_raw),
      .sync_out (pins_sync)
   );

   pin_sync #(.WIDTH(2)) u_sync_alt (
      .clk      (clk),
      .reset    (reset),
      .clk_en   (clk_en),
      .async_in ({alt_host_select_two_n, alt_host_write_strobe_n}),
      .sync_out (alt_sync)
   );

   wire [7:0] data_s;
   wire       addr_s;
   wire       rd_s;
   wire       cs_main_s;
   wire       wr_main_s;
   assign data_s    = pins_sync[11:4];
   assign addr_s    = pins_sync[3];
   assign rd_s      = pins_sync[2];
   assign cs_main_s = pins_sync[1];
   assign wr_main_s = pins_sync[0];

   // ==========================================================
   // registers
   reg  [7:0] out_byte_reg;
   reg  [7:0] in_byte_reg;
   reg  [7:0] flags_reg;
   reg  [7:0] stc_reg;
   wire       port_enabled;
   assign port_enabled = system_control_register[`SYSCTL_ENABLE_BIT];

   // ==========================================================
   // slave register decode: one select per register
   wire       sel_in_byte;
   wire       sel_out_byte;
   wire       sel_flags;
   wire       sel_stc;
   assign sel_in_byte  = (slave_sel == `SEL_IN_BYTE);
   assign sel_out_byte = (slave_sel == `SEL_OUT_BYTE);
   assign sel_flags    = (slave_sel == `SEL_FLAGS);
   assign sel_stc      = (slave_sel == `SEL_STC);

   // ==========================================================
   // pin switch: choose which pair carries select and write
   wire       stc_switch_bit;
   wire       switch_on;
   wire       cs_s;
   wire       wr_s;
   assign stc_switch_bit = stc_reg[`STC_PIN_SWITCH_BIT];
   assign switch_on = stc_switch_bit & port_enabled;
   assign cs_s = switch_on ? alt_sync[1] : cs_main_s;
   assign wr_s = switch_on ? alt_sync[0] : wr_main_s;

   // strobe qualified by select so a select-less edge never counts
   wire       host_selected;
   wire       host_wr_level;
   wire       host_rd_out_level;
   assign host_selected     = port_enabled & ~cs_s;
   assign host_wr_level     = ~(host_selected & ~wr_s);
   assign host_rd_out_level = ~(host_selected & ~rd_s & ~addr_s);

   wire       host_wr_rise;
   wire       host_rd_rise;
   wire       slave_rd_level;
   wire       slave_wr_level;
   wire       slave_rd_fall;
   wire       slave_wr_fall;
   assign slave_rd_level = slave_rd_strobe & sel_in_byte;
   assign slave_wr_level = slave_wr_strobe & sel_out_byte;

   edge_find u_host_wr (
      .clk      (clk),
      .reset    (reset),
      .clk_en   (clk_en),
      .level_in (host_wr_level),
      .rise     (host_wr_rise),
      .fall     ()
   );

   edge_find u_host_rd (
      .clk      (clk),
      .reset    (reset),
      .clk_en   (clk_en),
      .level_in (host_rd_out_level),
      .rise     (host_rd_rise),
      .fall     ()
   );

   // the edge finders idle high, so the active-high slave levels enter
   // inverted; fed straight in, the release of reset would fake a trailing edge
   wire       slave_rd_idle;
   wire       slave_wr_idle;
   assign slave_rd_idle = ~slave_rd_level;
   assign slave_wr_idle = ~slave_wr_level;

   edge_find u_slave_rd (
      .clk      (clk),
      .reset    (reset),
      .clk_en   (clk_en),
      .level_in (slave_rd_idle),
      .rise     (slave_rd_fall),
      .fall     ()
   );

   edge_find u_slave_wr (
      .clk      (clk),
      .reset    (reset),
      .clk_en   (clk_en),
      .level_in (slave_wr_idle),
      .rise     (slave_wr_fall),
      .fall     ()
   );

   // ==========================================================
   // flag events, named so the set-over-clear order below reads plainly
   wire       in_full_set;
   wire       in_full_clear;
   wire       out_full_set;
   wire       out_full_clear;
   wire       gp_write;
   wire       stc_write;
   assign in_full_set    = host_wr_rise;
   assign in_full_clear  = slave_rd_fall;
   assign out_full_set   = slave_wr_fall;
   assign out_full_clear = host_rd_rise;
   assign gp_write       = slave_wr_strobe & sel_flags;
   assign stc_write      = slave_wr_strobe & sel_stc;

   // data and address held during the strobe; sampled one cycle late
   reg [7:0] data_hold_reg;
   reg       addr_hold_reg;
   always @(posedge clk) begin
      if (clk_en && !host_wr_level) begin
         data_hold_reg <= data_s;
         addr_hold_reg <= addr_s;
      end
   end

   // ==========================================================
   // input and output bytes (no reset: contents undefined)
   always @(posedge clk) begin
      if (clk_en && in_full_set) begin
         in_byte_reg <= data_hold_reg;
      end
   end

   always @(posedge clk) begin
      if (clk_en && slave_wr_level) begin
         out_byte_reg <= slave_wdata;
      end
   end

   // ==========================================================
   // status flags
   wire [7:0] flags_written;
   assign flags_written = (flags_reg & `FLAGS_HW_MASK) | (slave_wdata & `FLAGS_GP_MASK);

   reg  [7:0] flags_next;
   always @* begin
      flags_next = flags_reg;
      if (gp_write) begin
         flags_next = flags_written;
      end
      if (in_full_set) begin
         flags_next[`FLAG_CMD_DATA_BIT] = addr_hold_reg;
      end
      // clear first so a same-cycle set wins
      if (in_full_clear) begin
         flags_next[`FLAG_INPUT_FULL_BIT] = 1'b0;
      end
      if (in_full_set) begin
         flags_next[`FLAG_INPUT_FULL_BIT] = 1'b1;
      end
      if (out_full_clear) begin
         flags_next[`FLAG_OUTPUT_FULL_BIT] = 1'b0;
      end
      if (out_full_set) begin
         flags_next[`FLAG_OUTPUT_FULL_BIT] = 1'b1;
      end
   end

   always @(posedge clk) begin
      if (reset || hw_standby) begin
         flags_reg <= `FLAGS_TWO_RESET;
      end else if (clk_en) begin
         flags_reg <= flags_next;
      end
   end

   // the pin switch lives in a shared control register; only bit 3 acts here
   always @(posedge clk) begin
      if (reset || hw_standby) begin
         stc_reg <= `STC_RESET;
      end else if (clk_en && stc_write) begin
         stc_reg <= slave_wdata;
      end
   end

   // ==========================================================
   // host read path: the host may only read, and the bus is driven
   // only while select and read strobe are both low
   reg  [7:0] host_data_next;
   reg        host_oe_n_next;
   always @* begin
      host_oe_n_next = ~(host_selected & ~rd_s);
      if (addr_s) begin
         host_data_next = flags_reg;
      end else begin
         host_data_next = out_byte_reg;
      end
   end

   wire       input_full_flag;
   assign input_full_flag = flags_reg[`FLAG_INPUT_FULL_BIT];

   // ==========================================================
   // registered outputs
   reg [7:0] slave_rdata_next;
   always @* begin
      case (slave_sel)
         `SEL_IN_BYTE:  slave_rdata_next = in_byte_reg;
         `SEL_OUT_BYTE: slave_rdata_next = out_byte_reg;
         `SEL_FLAGS:    slave_rdata_next = flags_reg;
         default:       slave_rdata_next = stc_reg;
      endcase
   end

   always @(posedge clk) begin
      if (reset) begin
         host_data_out     <= 8'h00;
         host_data_oe_n    <= 1'b1;
         slave_rdata       <= 8'h00;
         input_full_irq    <= 1'b0;
         pin_switch_select <= 1'b0;
      end else if (clk_en) begin
         host_data_oe_n    <= host_oe_n_next;
         host_data_out     <= host_data_next;
         slave_rdata       <= slave_rdata_next;
         input_full_irq    <= input_full_flag;
         pin_switch_select <= switch_on;
      end
   end
endmodule

// >>> tb/host_port_channel_two_checker.sv
`timescale 1ns/1ps
`include "host_port_two_map.vh"
// ====
// checker
module hp_two_checker (
   input wire       clk,
   input wire       reset,
   input wire       clk_en,
   input wire       hw_standby,
   input wire [7:0] system_control_register,
   input wire       host_write_strobe_n,
   input wire       alt_host_write_strobe_n,
   input wire       host_read_strobe_n,
   input wire       host_data_oe_n,
   input wire [1:0] slave_sel,
   input wire       slave_rd_strobe,
   input wire [7:0] slave_rdata,
   input wire       input_full_irq,
   input wire       pin_switch_select
);
   reg [3:0] wr_age_reg;
   // saturating age of the last host write, so an old write never explains a new flag
   always @(posedge clk) begin
      if (reset)
         wr_age_reg <= 4'hF;
      else if (!host_write_strobe_n || !alt_host_write_strobe_n)
         wr_age_reg <= 4'h0;
      else if (wr_age_reg != 4'hF)
         wr_age_reg <= wr_age_reg + 4'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_reset_quiet: assert property (disable iff (1'b0)
      reset && clk_en |=> host_data_oe_n && !input_full_irq && !pin_switch_select) else $error("reset");
   a_standby_clear: assert property (hw_standby ##1 clk_en |=> !input_full_irq && !pin_switch_select)
      else $error("standby");
   a_switch_gated: assert property (!system_control_register[`SYSCTL_ENABLE_BIT] && clk_en |=> !pin_switch_select)
      else $error("switch gate");
   a_switch_tracks: assert property (slave_sel == `SEL_STC && system_control_register[1] && clk_en
      |=> slave_rdata[3] == pin_switch_select) else $error("switch");
   a_idle_bus: assert property (host_read_strobe_n [*5] |=> host_data_oe_n) else $error("bus idle");
   a_off_bus: assert property (!system_control_register[1] [*4] |=> host_data_oe_n) else $error("off");
   a_irq_cause: assert property ($rose(input_full_irq) |-> wr_age_reg < 4'h9) else $error("irq set");
   a_irq_clear: assert property ($fell(slave_rd_strobe) && $past(slave_sel) == `SEL_IN_BYTE
      && wr_age_reg > 4'h6 |-> ##[1:4] !input_full_irq) else $error("irq clear");
endmodule
bind host_port_channel_two hp_two_checker i_hp_two_checker (.clk, .reset, .clk_en, .hw_standby,
   .system_control_register, .host_write_strobe_n, .alt_host_write_strobe_n, .host_read_strobe_n,
   .host_data_oe_n, .slave_sel, .slave_rd_strobe, .slave_rdata, .input_full_irq, .pin_switch_select);

// >>> tb/host_cpu_model.sv
`timescale 1ns/1ps
// ====
// host processor
module host_cpu_model (
   input  wire       clk,
   input  wire [7:0] host_data_out,
   input  wire       host_data_oe_n,
   output reg        host_address_bit,
   output reg        host_select_two_n,
   output reg        host_write_strobe_n,
   output reg        alt_host_select_two_n,
   output reg        alt_host_write_strobe_n,
   output reg        host_read_strobe_n,
   output wire [7:0] host_data_in
);
   reg       drv_reg;
   reg [7:0] bus_reg;
   reg [7:0] last_reg;
   // a floating bus shows the inverse of its last level so a stale byte never looks valid
   assign host_data_in = drv_reg ? bus_reg : (!host_data_oe_n ? host_data_out : ~last_reg);
   always @(posedge clk) if (drv_reg || host_data_oe_n === 1'b0) last_reg <= host_data_in;
   initial begin
      {host_address_bit, drv_reg, bus_reg, last_reg} = 18'h0;
      {host_select_two_n, host_write_strobe_n, host_read_strobe_n} = 3'h7;
      {alt_host_select_two_n, alt_host_write_strobe_n} = 2'h3;
   end
   task step(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr(input alt, input a0, input [7:0] d);
      step(1);
      {host_address_bit, bus_reg, drv_reg} = {a0, d, 1'b1};
      {host_select_two_n, alt_host_select_two_n} = {alt, !alt};
      step(2);
      {host_write_strobe_n, alt_host_write_strobe_n} = {alt, !alt};
      step(5);
      {host_write_strobe_n, alt_host_write_strobe_n} = 2'h3;
      step(5);
      {host_select_two_n, alt_host_select_two_n, drv_reg} = 3'h6;
   endtask
   task rd(input alt, input a0, output [7:0] d, output oe_n);
      step(1);
      host_address_bit = a0;
      {host_select_two_n, alt_host_select_two_n} = {alt, !alt};
      step(2);
      host_read_strobe_n = 1'b0;
      step(5);
      {d, oe_n} = {host_data_out, host_data_oe_n};
      host_read_strobe_n = 1'b1;
      step(5);
      {host_select_two_n, alt_host_select_two_n} = 2'h3;
   endtask
endmodule

// >>> tb/host_port_channel_two_tb.sv
`timescale 1ns/1ps
`include "host_port_two_map.vh"
// ====
// bench
module host_port_channel_two_tb;
   reg        clk, reset, clk_en, hw_standby, slave_rd_strobe, slave_wr_strobe, oe;
   reg  [7:0] system_control_register, slave_wdata, got;
   reg  [1:0] slave_sel;
   reg  [8:0] rows [0:3];
   wire [7:0] host_data_in, host_data_out, slave_rdata;
   wire       host_address_bit, host_select_two_n, host_write_strobe_n, host_read_strobe_n;
   wire       alt_host_select_two_n, alt_host_write_strobe_n;
   wire       host_data_oe_n, input_full_irq, pin_switch_select;
   integer    err_total, compares, cyc, i;
   host_port_channel_two i_host_port_channel_two (.clk, .reset, .clk_en, .hw_standby,
      .system_control_register, .host_address_bit, .host_select_two_n, .host_write_strobe_n,
      .alt_host_select_two_n, .alt_host_write_strobe_n, .host_read_strobe_n, .host_data_in,
      .host_data_out, .host_data_oe_n, .slave_sel, .slave_rd_strobe, .slave_wr_strobe,
      .slave_wdata, .slave_rdata, .input_full_irq, .pin_switch_select);
   host_cpu_model i_host_cpu_model (.clk, .host_data_out, .host_data_oe_n, .host_address_bit,
      .host_select_two_n, .host_write_strobe_n, .alt_host_select_two_n,
      .alt_host_write_strobe_n, .host_read_strobe_n, .host_data_in);
   task chk(input [7:0] g, input [7:0] e);
      compares = compares + 1;
      if (g !== e) begin
         err_total = err_total + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task sw(input [1:0] s, input [7:0] d);
      {slave_sel, slave_wdata, slave_wr_strobe} = {s, d, 1'b1};
      @(posedge clk) #1;
      slave_wr_strobe = 1'b0;
      @(posedge clk) #1;
   endtask
   // the input full flag clears one edge and the interrupt two edges after the strobe drops, so the read waits before returning
   task sr(input [1:0] s);
      {slave_sel, slave_rd_strobe} = {s, 1'b1};
      @(posedge clk) #1;
      {got, slave_rd_strobe} = {slave_rdata, 1'b0};
      repeat (3) @(posedge clk);
      #1;
   endtask
   task give_verdict;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         give_verdict;
      end
   end
   initial begin
      {err_total, compares, cyc} = 0;
      {clk_en, reset, hw_standby, slave_rd_strobe, slave_wr_strobe} = 5'h18;
      {slave_sel, slave_wdata, system_control_register} = 18'h00002;
      {rows[0], rows[1], rows[2], rows[3]} = {9'h03C, 9'h1A5, 9'h0FF, 9'h100};
      repeat (4) @(posedge clk);
      #1 reset = 1'b0;
      sr(`SEL_FLAGS);
      chk(got, `FLAGS_TWO_RESET);
      sr(`SEL_STC);
      chk(got, `STC_RESET);
      chk({input_full_irq, pin_switch_select}, 8'h00);
      $display("done: reset");
      for (i = 0; i < 4; i = i + 1) begin
         i_host_cpu_model.wr(1'b0, rows[i][8], rows[i][7:0]);
         sr(`SEL_FLAGS);
         chk(got, {4'h0, rows[i][8], 3'h2});
         chk(input_full_irq, 8'h01);
         sr(`SEL_IN_BYTE);
         chk(got, rows[i][7:0]);
         sr(`SEL_FLAGS);
         chk(got, {4'h0, rows[i][8], 3'h0});
      end
      $display("done: host writes");
      sw(`SEL_FLAGS, 8'h00);
      sr(`SEL_FLAGS);
      chk(got, 8'h08);
      sw(`SEL_FLAGS, 8'hFF);
      sr(`SEL_FLAGS);
      chk(got, 8'hFC);
      i_host_cpu_model.rd(1'b0, 1'b1, got, oe);
      chk({got, oe}, 9'h1F8);
      $display("done: status");
      sw(`SEL_OUT_BYTE, 8'h5A);
      sr(`SEL_FLAGS);
      chk(got, 8'hFD);
      i_host_cpu_model.rd(1'b0, 1'b0, got, oe);
      chk({got, oe}, 9'h0B4);
      sr(`SEL_FLAGS);
      chk(got, 8'hFC);
      $display("done: output byte");
      system_control_register = 8'h00;
      sw(`SEL_STC, 8'h08);
      chk(pin_switch_select, 8'h00);
      i_host_cpu_model.wr(1'b0, 1'b0, 8'h11);
      i_host_cpu_model.rd(1'b0, 1'b1, got, oe);
      chk(oe, 8'h01);
      sr(`SEL_FLAGS);
      chk(got, 8'hFC);
      system_control_register = 8'h02;
      sr(`SEL_STC);
      chk({got, pin_switch_select}, 9'h011);
      i_host_cpu_model.wr(1'b0, 1'b0, 8'h22);
      sr(`SEL_FLAGS);
      chk(got, 8'hFC);
      i_host_cpu_model.wr(1'b1, 1'b0, 8'h33);
      sr(`SEL_FLAGS);
      chk(got, 8'hF6);
      sr(`SEL_IN_BYTE);
      chk(got, 8'h33);
      $display("done: pin switch");
      clk_en = 1'b0;
      sw(`SEL_FLAGS, 8'h00);
      clk_en = 1'b1;
      sr(`SEL_FLAGS);
      chk(got, 8'hF4);
      $display("done: clock enable");
      hw_standby = 1'b1;
      @(posedge clk) #1;
      hw_standby = 1'b0;
      sr(`SEL_FLAGS);
      chk(got, `FLAGS_TWO_RESET);
      sr(`SEL_STC);
      chk(got, `STC_RESET);
      $display("done: standby");
      give_verdict;
   end
endmodule
